/* rtl/rcr_defines.svh */
// Register indices, field positions, reset values of the regulator control bank
`ifndef RCR_DEFINES_SVH
`define RCR_DEFINES_SVH

`define RCR_ADDR_W 10
`define RCR_IDX_BUCK_A_PRI 8'h20
`define RCR_IDX_BUCK_A_SEC 8'h21
`define RCR_IDX_BUCK_A_CTRL 8'h22
`define RCR_IDX_BUCK_B_PRI 8'h30
`define RCR_IDX_BUCK_B_SEC 8'h31
`define RCR_IDX_BUCK_B_CTRL 8'h32
`define RCR_IDX_BUCK_C_PRI 8'h40
`define RCR_IDX_BUCK_C_SEC 8'h41
`define RCR_IDX_BUCK_C_CTRL 8'h42
`define RCR_IDX_LDO_D_VOLT 8'h50
`define RCR_IDX_LDO_D_CTRL 8'h51
`define RCR_IDX_LDO_E_VOLT 8'h54
`define RCR_IDX_LDO_E_CTRL 8'h55
`define RCR_IDX_INT_STAT 8'h80
`define RCR_IDX_INT_EN 8'h81
`define RCR_IDX_INT_CLR 8'h82

`define RCR_BIT_ON 7
`define RCR_BIT_PHASE 6
`define RCR_BIT_DIS 6
`define RCR_BIT_MODE 5
`define RCR_BIT_LOW_QUIESCENT_SELECT 5
`define RCR_BIT_DELAY_HI 4
`define RCR_BIT_DELAY_LO 2
`define RCR_BIT_FEN 1
`define RCR_BIT_PG 0
`define RCR_BIT_VCODE_HI 5

`define RCR_RST_VCODE 6'h00
`define RCR_RST_ON 1'b0
`define RCR_RST_PHASE 1'b0
`define RCR_RST_MODE 1'b0
`define RCR_RST_DIS 1'b0
`define RCR_RST_LOW_QUIESCENT_SELECT 1'b0
`define RCR_RST_DELAY 3'h0
`define RCR_RST_FEN 1'b0
`define RCR_RST_IEN 5'h00

`endif

/* rtl/rcr_pkg.sv */
// Types of the regulator control bank
package rcr_pkg;
  // Regulator order: 0..2 buck a,b,c; 3,4 ldo d,e
  typedef struct packed {
    logic ack;
    logic [31:0] rdat;
    logic [2:0][5:0] vpri;
    logic [2:0][5:0] vsec;
    logic [1:0][5:0] lvolt;
    logic [4:0] on;
    logic [4:0][2:0] delay;
    logic [4:0] fen;
    logic [1:0] phase;
    logic [2:0] pwm;
    logic [1:0] dis;
    logic [1:0] low_quiescent_select;
    logic [4:0] pg;
    logic [4:0] stat;
    logic [4:0] ien;
    logic irq;
    logic [2:0][5:0] bcode;
  } rcr_state_t;
endpackage

/* rtl/rcr_regulator_regs.sv */
// Wishbone register bank controlling three buck converters and two linear regulators
`include "rcr_defines.svh"

module rcr_regulator_regs (
  input wire logic clock,
  input wire logic resetn,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [`RCR_ADDR_W-1:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic voltage_select_pin,
  input wire logic [4:0] power_good,
  output logic [17:0] buck_voltage_code,
  output logic [11:0] ldo_voltage_code,
  output logic [4:0] regulator_enable,
  output logic [14:0] regulator_delay,
  output logic [1:0] buck_phase_shift,
  output logic [2:0] buck_forced_pwm,
  output logic [1:0] ldo_output_discharge_enable,
  output logic [1:0] ldo_low_quiescent_select,
  output logic irq
);

  rcr_pkg::rcr_state_t s_r;
  rcr_pkg::rcr_state_t s_nxt;
  logic [7:0] idx;
  logic req;
  logic wr;
  logic rd;
  logic [7:0] wbyte;
  logic [4:0] fault_ev;

  assign idx = wb_adr_i[`RCR_ADDR_W-1:2];
  // One request per ack; the cycle carrying ack is not a new request
  assign req = wb_cyc_i & wb_stb_i & ~s_r.ack;
  assign wr = req & wb_we_i & wb_sel_i[0];
  assign rd = req & ~wb_we_i;
  assign wbyte = wb_dat_i[7:0];

  // Compose a control byte for regulator i
  function automatic logic [7:0] ctrl_byte(input rcr_pkg::rcr_state_t s, input int i);
    logic [7:0] b;
    b = 8'h00;
    b[`RCR_BIT_ON] = s.on[i];
    if (i < 2) begin
      b[`RCR_BIT_PHASE] = s.phase[i];
    end else if (i > 2) begin
      b[`RCR_BIT_DIS] = s.dis[i-3];
    end
    if (i < 3) begin
      b[`RCR_BIT_MODE] = s.pwm[i];
    end else begin
      b[`RCR_BIT_LOW_QUIESCENT_SELECT] = s.low_quiescent_select[i-3];
    end
    b[`RCR_BIT_DELAY_HI:`RCR_BIT_DELAY_LO] = s.delay[i];
    b[`RCR_BIT_FEN] = s.fen[i];
    b[`RCR_BIT_PG] = s.pg[i];
    return b;
  endfunction

  always_comb begin
    logic [7:0] rbyte;
    logic [4:0] clr;
    int ci;
    rbyte = 8'h00;
    clr = 5'h00;
    ci = -1;
    s_nxt = s_r;
    s_nxt.ack = req;
    unique case (idx)
      `RCR_IDX_BUCK_A_PRI: begin
        rbyte = {2'b00, s_r.vpri[0]};
        if (wr) s_nxt.vpri[0] = wbyte[`RCR_BIT_VCODE_HI:0];
      end
      `RCR_IDX_BUCK_A_SEC: begin
        rbyte = {2'b00, s_r.vsec[0]};
        if (wr) s_nxt.vsec[0] = wbyte[`RCR_BIT_VCODE_HI:0];
      end
      `RCR_IDX_BUCK_B_PRI: begin
        rbyte = {2'b00, s_r.vpri[1]};
        if (wr) s_nxt.vpri[1] = wbyte[`RCR_BIT_VCODE_HI:0];
      end
      `RCR_IDX_BUCK_B_SEC: begin
        rbyte = {2'b00, s_r.vsec[1]};
        if (wr) s_nxt.vsec[1] = wbyte[`RCR_BIT_VCODE_HI:0];
      end
      `RCR_IDX_BUCK_C_PRI: begin
        rbyte = {2'b00, s_r.vpri[2]};
        if (wr) s_nxt.vpri[2] = wbyte[`RCR_BIT_VCODE_HI:0];
      end
      `RCR_IDX_BUCK_C_SEC: begin
        rbyte = {2'b00, s_r.vsec[2]};
        if (wr) s_nxt.vsec[2] = wbyte[`RCR_BIT_VCODE_HI:0];
      end
      `RCR_IDX_LDO_D_VOLT: begin
        rbyte = {2'b00, s_r.lvolt[0]};
        if (wr) s_nxt.lvolt[0] = wbyte[`RCR_BIT_VCODE_HI:0];
      end
      `RCR_IDX_LDO_E_VOLT: begin
        rbyte = {2'b00, s_r.lvolt[1]};
        if (wr) s_nxt.lvolt[1] = wbyte[`RCR_BIT_VCODE_HI:0];
      end
      `RCR_IDX_BUCK_A_CTRL: ci = 0;
      `RCR_IDX_BUCK_B_CTRL: ci = 1;
      `RCR_IDX_BUCK_C_CTRL: ci = 2;
      `RCR_IDX_LDO_D_CTRL: ci = 3;
      `RCR_IDX_LDO_E_CTRL: ci = 4;
      `RCR_IDX_INT_STAT: rbyte = {3'b000, s_r.stat};
      `RCR_IDX_INT_EN: begin
        rbyte = {3'b000, s_r.ien};
        if (wr) s_nxt.ien = wbyte[4:0];
      end
      `RCR_IDX_INT_CLR: begin
        if (wr) clr = wbyte[4:0];
      end
      // Unmapped: acked, reads zero, writes dropped
      default: rbyte = 8'h00;
    endcase
    if (ci >= 0) begin
      rbyte = ctrl_byte(s_r, ci);
      if (wr) begin
        s_nxt.on[ci] = wbyte[`RCR_BIT_ON];
        s_nxt.delay[ci] = wbyte[`RCR_BIT_DELAY_HI:`RCR_BIT_DELAY_LO];
        s_nxt.fen[ci] = wbyte[`RCR_BIT_FEN];
        if (ci < 2) begin
          s_nxt.phase[ci] = wbyte[`RCR_BIT_PHASE];
        end
        if (ci < 3) begin
          s_nxt.pwm[ci] = wbyte[`RCR_BIT_MODE];
        end else begin
          s_nxt.dis[ci-3] = wbyte[`RCR_BIT_DIS];
          s_nxt.low_quiescent_select[ci-3] = wbyte[`RCR_BIT_LOW_QUIESCENT_SELECT];
        end
      end
    end
    if (req) s_nxt.rdat = {24'h000000, rbyte};
    s_nxt.pg = power_good;
    // gated fault events; set beats clear
    s_nxt.stat = (s_r.stat & ~clr) | fault_ev;
    s_nxt.irq = |(s_nxt.stat & s_nxt.ien);
    for (int i = 0; i < 3; i++) begin
      s_nxt.bcode[i] = voltage_select_pin ? s_r.vsec[i] : s_r.vpri[i];
    end
  end

  // Fault: an enabled regulator with its fen bit set losing power-good
  genvar g;
  generate
    for (g = 0; g < 5; g++) begin : gen_fault
      assign fault_ev[g] = s_r.pg[g] & ~power_good[g] & s_r.on[g] & s_r.fen[g];
    end
  endgenerate

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      s_r.ack <= 1'b0;
      s_r.rdat <= 32'h00000000;
      s_r.vpri <= {3{`RCR_RST_VCODE}};
      s_r.vsec <= {3{`RCR_RST_VCODE}};
      s_r.lvolt <= {2{`RCR_RST_VCODE}};
      s_r.on <= {5{`RCR_RST_ON}};
      s_r.delay <= {5{`RCR_RST_DELAY}};
      s_r.fen <= {5{`RCR_RST_FEN}};
      s_r.phase <= {2{`RCR_RST_PHASE}};
      s_r.pwm <= {3{`RCR_RST_MODE}};
      s_r.dis <= {2{`RCR_RST_DIS}};
      s_r.low_quiescent_select <= {2{`RCR_RST_LOW_QUIESCENT_SELECT}};
      s_r.pg <= 5'h00;
      s_r.stat <= 5'h00;
      s_r.ien <= `RCR_RST_IEN;
      s_r.irq <= 1'b0;
      s_r.bcode <= {3{`RCR_RST_VCODE}};
    end else begin
      s_r <= s_nxt;
    end
  end

  assign wb_dat_o = s_r.rdat;
  assign wb_ack_o = s_r.ack;
  assign buck_voltage_code = s_r.bcode;
  assign ldo_voltage_code = s_r.lvolt;
  assign regulator_enable = s_r.on;
  assign regulator_delay = s_r.delay;
  assign buck_phase_shift = s_r.phase;
  assign buck_forced_pwm = s_r.pwm;
  assign ldo_output_discharge_enable = s_r.dis;
  assign ldo_low_quiescent_select = s_r.low_quiescent_select;
  assign irq = s_r.irq;

  // Checks
  AST_PRI_CODE: assert property (@(posedge clock) disable iff (!resetn)
    !voltage_select_pin |=> buck_voltage_code == $past(s_r.vpri))
    else $error("buck code not primary with select low");

  AST_SEC_CODE: assert property (@(posedge clock) disable iff (!resetn)
    voltage_select_pin |=> buck_voltage_code == $past(s_r.vsec))
    else $error("buck code not secondary with select high");

  AST_ENABLE_WRITE: assert property (@(posedge clock) disable iff (!resetn)
    wr && idx == `RCR_IDX_BUCK_A_CTRL |=> regulator_enable[0] == $past(wb_dat_i[7]) ##1 wb_ack_o == 1'b0)
    else $error("enable bit write not applied");

  AST_PHASE_WRITE: assert property (@(posedge clock) disable iff (!resetn)
    wr && idx == `RCR_IDX_BUCK_B_CTRL |=> buck_phase_shift[1] == $past(wb_dat_i[6]) && wb_ack_o)
    else $error("phase bit write not applied");

  AST_PWM_WRITE: assert property (@(posedge clock) disable iff (!resetn)
    wr && idx == `RCR_IDX_BUCK_C_CTRL |=> buck_forced_pwm[2] == $past(wb_dat_i[5]))
    else $error("pwm bit write not applied");

  AST_DELAY_WRITE: assert property (@(posedge clock) disable iff (!resetn)
    wr && idx == `RCR_IDX_LDO_D_CTRL |=> regulator_delay[11:9] == $past(wb_dat_i[4:2]))
    else $error("delay field write not applied");

  AST_FAULT_GATE: assert property (@(posedge clock) disable iff (!resetn)
    $rose(s_r.stat[0]) |-> $past(s_r.fen[0]) && $past(s_r.on[0]) && $past(s_r.pg[0]))
    else $error("fault status set without enabled fault");

  AST_PG_READ: assert property (@(posedge clock) disable iff (!resetn)
    rd && idx == `RCR_IDX_BUCK_A_CTRL |=> wb_ack_o && wb_dat_o[0] == $past(s_r.pg[0]))
    else $error("power-good read mismatch");

  AST_DIS_WRITE: assert property (@(posedge clock) disable iff (!resetn)
    wr && idx == `RCR_IDX_LDO_E_CTRL |=> ldo_output_discharge_enable[1] == $past(wb_dat_i[6]))
    else $error("discharge bit write not applied");

  AST_LOW_QUIESCENT_SELECT_WRITE: assert property (@(posedge clock) disable iff (!resetn)
    wr && idx == `RCR_IDX_LDO_D_CTRL |=> ldo_low_quiescent_select[0] == $past(wb_dat_i[5]))
    else $error("low quiescent bit write not applied");

  AST_LDO_CODE: assert property (@(posedge clock) disable iff (!resetn)
    wr && idx == `RCR_IDX_LDO_E_VOLT |=> ldo_voltage_code[11:6] == $past(wb_dat_i[5:0]))
    else $error("ldo code write not applied");

  AST_RSVD_ZERO: assert property (@(posedge clock) disable iff (!resetn)
    rd && (idx == `RCR_IDX_BUCK_C_CTRL || idx == `RCR_IDX_BUCK_B_PRI) |=> wb_dat_o[31:8] == 24'h000000 &&
    wb_dat_o[6] == 1'b0)
    else $error("reserved bits not zero");

  AST_STAT_SET_WINS: assert property (@(posedge clock) disable iff (!resetn)
    fault_ev[1] |=> s_r.stat[1] && irq == |(s_r.stat & s_r.ien))
    else $error("fault event lost");

  // Bus handshake: one ack per request, one cycle long
  AST_ACK_AFTER_REQ: assert property (@(posedge clock) disable iff (!resetn)
    req |=> wb_ack_o)
    else $error("request not acknowledged");

  AST_ACK_ONE_CYCLE: assert property (@(posedge clock) disable iff (!resetn)
    wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");

  AST_RDAT_HIGH_ZERO: assert property (@(posedge clock) disable iff (!resetn)
    wb_ack_o |-> wb_dat_o[31:8] == 24'h000000)
    else $error("read data upper bytes not zero");

  AST_VOLT_RSVD: assert property (@(posedge clock) disable iff (!resetn)
    rd && idx == `RCR_IDX_LDO_D_VOLT |=> wb_dat_o[7:6] == 2'b00)
    else $error("voltage register reserved bits not zero");

  AST_PG_TRACK: assert property (@(posedge clock) disable iff (!resetn)
    wr && idx == `RCR_IDX_LDO_E_CTRL |=> s_r.pg == $past(power_good))
    else $error("power-good changed by a write");

  AST_ENABLE_HOLD: assert property (@(posedge clock) disable iff (!resetn)
    !wr |=> regulator_enable == $past(regulator_enable))
    else $error("enable changed without a write");

  AST_DELAY_HOLD: assert property (@(posedge clock) disable iff (!resetn)
    !wr |=> regulator_delay == $past(regulator_delay))
    else $error("delay changed without a write");

  AST_PHASE_HOLD: assert property (@(posedge clock) disable iff (!resetn)
    !wr |=> buck_phase_shift == $past(buck_phase_shift))
    else $error("phase changed without a write");

  AST_LDO_HOLD: assert property (@(posedge clock) disable iff (!resetn)
    !wr |=> ldo_voltage_code == $past(ldo_voltage_code))
    else $error("ldo code changed without a write");

  AST_IRQ_LEVEL: assert property (@(posedge clock) disable iff (!resetn)
    irq == |(s_r.stat & s_r.ien))
    else $error("irq does not follow enabled status");

  // Sticky until cleared by software
  AST_STAT_STICKY: assert property (@(posedge clock) disable iff (!resetn)
    s_r.stat[0] && !(wr && idx == `RCR_IDX_INT_CLR && wbyte[0]) |=> s_r.stat[0])
    else $error("status bit lost without clear");

  AST_CLR_WORKS: assert property (@(posedge clock) disable iff (!resetn)
    wr && idx == `RCR_IDX_INT_CLR && wbyte[2] && !fault_ev[2] |=> !s_r.stat[2])
    else $error("status bit not cleared");

  AST_SET_BEATS_CLR: assert property (@(posedge clock) disable iff (!resetn)
    wr && idx == `RCR_IDX_INT_CLR && wbyte[3] && fault_ev[3] |=> s_r.stat[3])
    else $error("clear overrode a new fault");

endmodule

/* verification/tb.sv */
// Self-checking bench of the regulator control register bank
`define CHK(g, e) chk(32'(g), 32'(e))
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic clock, resetn, wb_cyc_i, wb_stb_i, wb_we_i, voltage_select_pin, wb_ack_o, irq;
  logic [9:0] wb_adr_i;
  logic [3:0] wb_sel_i;
  logic [31:0] wb_dat_i, wb_dat_o, q;
  logic [4:0] power_good, regulator_enable;
  logic [17:0] buck_voltage_code;
  logic [11:0] ldo_voltage_code;
  logic [14:0] regulator_delay;
  logic [1:0] buck_phase_shift, ldo_output_discharge_enable, ldo_low_quiescent_select;
  logic [2:0] buck_forced_pwm;
  logic [7:0] rv;
  logic [5:0] vc [8];
  logic [7:0] ctrl_idx [5] = '{8'h22, 8'h32, 8'h42, 8'h51, 8'h55};
  logic [7:0] volt_idx [8] = '{8'h20, 8'h21, 8'h30, 8'h31, 8'h40, 8'h41, 8'h50, 8'h54};
  int miscompares = 0;
  int n_checks = 0;
  int cycles = 0;

  rcr_regulator_regs u_rcr_regulator_regs (
    .clock(clock), .resetn(resetn), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
    .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o), .voltage_select_pin(voltage_select_pin), .power_good(power_good),
    .buck_voltage_code(buck_voltage_code), .ldo_voltage_code(ldo_voltage_code),
    .regulator_enable(regulator_enable), .regulator_delay(regulator_delay),
    .buck_phase_shift(buck_phase_shift), .buck_forced_pwm(buck_forced_pwm),
    .ldo_output_discharge_enable(ldo_output_discharge_enable),
    .ldo_low_quiescent_select(ldo_low_quiescent_select), .irq(irq)
  );

  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end

  task automatic end_sim();
    $display("checks %0d miscompares %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // One classic cycle; the global cycle ceiling bounds the wait for ack
  task automatic access(input logic [7:0] idx, input logic w, input logic [7:0] d);
    @(posedge clock);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= w;
    wb_adr_i <= {idx, 2'b00};
    wb_dat_i <= {24'h000000, d};
    do @(posedge clock); while (wb_ack_o !== 1'b1);
    q = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    wb_we_i <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] idx, input logic [7:0] d);
    access(idx, 1'b1, d);
  endtask

  task automatic rdchk(input logic [7:0] idx, input logic [7:0] exp);
    access(idx, 1'b0, 8'h00);
    `CHK(q, {24'h000000, exp});
  endtask

  always @(posedge clock) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      miscompares++;
      end_sim();
    end
  end

  initial begin
    resetn = 1'b0;
    wb_cyc_i = 1'b0;
    wb_stb_i = 1'b0;
    wb_we_i = 1'b0;
    wb_adr_i = 10'h000;
    wb_sel_i = 4'h1;
    wb_dat_i = 32'h00000000;
    voltage_select_pin = 1'b0;
    power_good = 5'h0a;
    repeat (12) @(posedge clock);
    resetn <= 1'b1;
    for (int i = 0; i < 8; i++) rdchk(volt_idx[i], 8'h00);
    for (int i = 0; i < 5; i++) rdchk(ctrl_idx[i], {7'h00, power_good[i]});
    rdchk(8'h81, 8'h00);
    // All ones, then a mixed pattern with the power-good bit written high
    for (int p = 0; p < 2; p++) begin
      rv = p ? 8'h57 : 8'hff;
      for (int i = 0; i < 5; i++) begin
        wr(ctrl_idx[i], rv);
        rdchk(ctrl_idx[i], (rv & (i == 2 ? 8'hbe : 8'hfe)) | {7'h00, power_good[i]});
      end
      `CHK(regulator_enable, p ? 5'h00 : 5'h1f);
      `CHK(buck_phase_shift, 2'h3);
      `CHK(buck_forced_pwm, p ? 3'h0 : 3'h7);
      `CHK(regulator_delay, p ? {5{3'b101}} : 15'h7fff);
      `CHK(ldo_output_discharge_enable, 2'h3);
      `CHK(ldo_low_quiescent_select, p ? 2'h0 : 2'h3);
    end
    for (int i = 0; i < 8; i++) begin
      vc[i] = 6'(i * 9 + 5);
      wr(volt_idx[i], {2'b11, vc[i]});
      rdchk(volt_idx[i], {2'b00, vc[i]});
    end
    repeat (2) @(posedge clock);
    `CHK(buck_voltage_code, {vc[4], vc[2], vc[0]});
    `CHK(ldo_voltage_code, {vc[7], vc[6]});
    voltage_select_pin <= 1'b1;
    repeat (3) @(posedge clock);
    `CHK(buck_voltage_code, {vc[5], vc[3], vc[1]});
    // Fault on two enabled outputs, only one with its fen bit set; all interrupt enables set
    power_good <= 5'h1f;
    wr(8'h81, 8'h1f);
    wr(8'h22, 8'h80);
    wr(8'h32, 8'h82);
    power_good <= 5'h1c;
    repeat (3) @(posedge clock);
    rdchk(8'h80, 8'h02);
    `CHK(irq, 1'b1);
    wr(8'h81, 8'h00);
    repeat (2) @(posedge clock);
    `CHK(irq, 1'b0);
    wr(8'h82, 8'h02);
    rdchk(8'h80, 8'h00);
    wr(8'h10, 8'hff);
    rdchk(8'h10, 8'h00);
    wr(8'h80, 8'hff);
    rdchk(8'h80, 8'h00);
    // Reset in mid-run drops every setting
    wr(8'h51, 8'hff);
    resetn <= 1'b0;
    repeat (2) @(posedge clock);
    `CHK(regulator_enable, 5'h00);
    `CHK(ldo_voltage_code, 12'h000);
    resetn <= 1'b1;
    rdchk(8'h51, {7'h00, power_good[3]});
    rdchk(8'h50, 8'h00);
    end_sim();
  end
endmodule
